/* hw/iord_decoder.sv */
// What this block does
// - bit set/clear only at io 0x00-0x1f
// - skip tests sample one bit, low range
// - writing one clears flags, zero keeps
// - bit set/clear touches only addressed bit
// - port in/out use io addresses 0x00-0x3f
// - data-space access at io address plus 0x20
`timescale 1ns/100ps
`default_nettype none
module iord_decoder
	import iord_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    sys_rst,
	input  wire iord_req_t               req,
	input  wire iord_flag_evt_t          flag_evt,
	input  wire logic [7:0]              port_a_pins,
	input  wire logic [7:0]              port_b_pins,
	input  wire logic [7:0]              port_d_pins,
	output var  iord_rsp_t               rsp,
	output var  logic [IO_REGS-1:0][7:0] reg_view
);

	logic [IO_REGS-1:0][7:0] store_reg;
	logic [IO_REGS-1:0][7:0] store_next;
	iord_rsp_t               rsp_reg;
	iord_rsp_t               rsp_next;

	logic       is_data;
	logic       is_write;
	logic       is_test;
	logic       addr_ok;
	logic       hit;
	logic       bit_ok;
	logic [7:0] io_addr;
	logic [7:0] wen;
	logic [7:0] wbits;
	logic [7:0] live_val;
	logic [7:0] rd_val;

	// address translation and operation decode
	always_comb begin
		is_data  = (req.op == OP_DATA_SPACE_LOAD) ||
			(req.op == OP_DATA_SPACE_PUT);
		is_test  = (req.op == OP_SKIP_WHEN_IO_BIT_HIGH) ||
			(req.op == OP_SKIP_WHEN_IO_BIT_LOW);
		if (is_data) begin
			// below the offset this wraps; the range test refuses it
			io_addr = req.addr - DATA_OFS;
			addr_ok = (req.addr >= DATA_OFS) &&
				(io_addr <= IO_TOP);
		end else begin
			io_addr = req.addr;
			addr_ok = req.addr <= IO_TOP;
		end
		// registers above 0x29 live elsewhere, so no hit here
		hit    = req.valid && addr_ok && (io_addr < 8'(IO_REGS));
		// bit ops gated to low range
		bit_ok = io_addr <= BIT_TOP;
		wen    = 8'h00;
		wbits  = 8'h00;
		unique case (req.op)
			OP_PORT_OUT, OP_DATA_SPACE_PUT: begin
				wen   = 8'hff;
				wbits = req.wdata;
			end
			OP_SET_IO_BIT_OP: begin
				wen   = bit_ok ? 8'h01 << req.bit_sel : 8'h00;
				wbits = wen;
			end
			OP_CLEAR_IO_BIT_OP: begin
				wen   = bit_ok ? 8'h01 << req.bit_sel : 8'h00;
				wbits = 8'h00;
			end
			OP_PORT_IN, OP_DATA_SPACE_LOAD,
			OP_SKIP_WHEN_IO_BIT_HIGH, OP_SKIP_WHEN_IO_BIT_LOW: begin
				wen   = 8'h00;
				wbits = 8'h00;
			end
		endcase
		is_write = hit && (wen != 8'h00);
	end

	// read path: pins are live, everything else from storage
	always_comb begin
		unique case (io_addr)
			ADDR_PORT_A_PIN: live_val = port_a_pins;
			ADDR_PORT_B_PIN: live_val = port_b_pins;
			ADDR_PORT_D_PIN: live_val = port_d_pins;
			default: begin
				if (io_addr < 8'(IO_REGS)) begin
					live_val = store_reg[io_addr[5:0]];
				end else begin
					live_val = 8'h00;
				end
			end
		endcase
		// reserved bits and addresses read zero
		rd_val = hit ? (live_val & iord_rd_mask(io_addr)) : 8'h00;
	end

	// per-register next value
	genvar gi;
	generate
		for (gi = 0; gi < IO_REGS; gi++) begin : g_entry
			localparam logic [7:0] A   = 8'(gi);
			localparam logic [7:0] W1C = iord_w1c_mask(A);
			localparam logic [7:0] WRM = iord_wr_mask(A) & ~W1C;
			logic       sel;
			logic [7:0] plain_en;
			logic [7:0] clr;
			logic [7:0] set;
			always_comb begin
				sel      = is_write && (io_addr == A);
				// reserved addresses have empty masks, so
				// a stray write there lands nowhere
				plain_en = sel ? (wen & WRM) : 8'h00;
				clr      = sel ? (wen & wbits & W1C) : 8'h00;
				unique case (A)
					ADDR_COMPARATOR_CTRL: set = flag_evt.comparator;
					ADDR_SERIAL_STATUS_A: set = flag_evt.serial_status;
					ADDR_USI_STATUS:      set = flag_evt.usi_status;
					ADDR_WATCHDOG_CTRL:   set = flag_evt.watchdog;
					default:              set = 8'h00;
				endcase
				set = set & W1C;
				// set beats clear so no event is lost
				store_next[gi] = (store_reg[gi] & ~plain_en & ~clr) |
					(wbits & plain_en) | set;
			end
		end
	endgenerate

	// answer for the request, ready next edge
	always_comb begin
		rsp_next.valid = req.valid;
		rsp_next.hit   = hit;
		// sample one bit, low range only
		rsp_next.skip  = hit && is_test && bit_ok &&
			(rd_val[req.bit_sel] ==
			(req.op == OP_SKIP_WHEN_IO_BIT_HIGH));
		rsp_next.rdata = ((req.op == OP_PORT_IN) ||
			(req.op == OP_DATA_SPACE_LOAD)) ? rd_val : 8'h00;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			store_reg <= {IO_REGS{RESET_VAL}};
			rsp_reg   <= '0;
		end else begin
			store_reg <= store_next;
			rsp_reg   <= rsp_next;
		end
	end

	assign rsp      = rsp_reg;
	assign reg_view = store_reg;

	// helper state that only the checks read; it drives no output,
	// so synthesis drops it and the real registers pay nothing
	logic [5:0] chk_idx_reg;
	logic [7:0] chk_old_reg;
	logic [7:0] chk_wdata_reg;
	logic [2:0] chk_bit_reg;
	logic       chk_bitval_reg;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			chk_idx_reg    <= 6'h00;
			chk_old_reg    <= 8'h00;
			chk_wdata_reg  <= 8'h00;
			chk_bit_reg    <= 3'h0;
			chk_bitval_reg <= 1'b0;
		end else begin
			chk_idx_reg    <= hit ? io_addr[5:0] : 6'h00;
			chk_old_reg    <= hit ? store_reg[io_addr[5:0]] : 8'h00;
			chk_wdata_reg  <= req.wdata;
			chk_bit_reg    <= req.bit_sel;
			chk_bitval_reg <= rd_val[req.bit_sel];
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	high_bit_blocked_a: assert property (
		req.valid && req.op == OP_SET_IO_BIT_OP && !bit_ok &&
		flag_evt == '0 |=> store_reg == $past(store_reg))
		else $error("bit set reached an address above 0x1f");

	skip_high_a: assert property (
		hit && bit_ok && req.op == OP_SKIP_WHEN_IO_BIT_HIGH
		|=> rsp.skip == chk_bitval_reg)
		else $error("skip-high result differs from bit");

	skip_low_a: assert property (
		hit && bit_ok && req.op == OP_SKIP_WHEN_IO_BIT_LOW
		|=> rsp.skip == !chk_bitval_reg)
		else $error("skip-low result differs from bit");

	flag_clear_a: assert property (
		hit && req.op == OP_PORT_OUT && flag_evt == '0 &&
		(req.wdata & iord_w1c_mask(io_addr)) != 8'h00
		|=> (store_reg[chk_idx_reg] & chk_wdata_reg &
		iord_w1c_mask({2'b00, chk_idx_reg})) == 8'h00)
		else $error("flag not cleared by writing one");

	flag_keep_a: assert property (
		hit && req.op == OP_DATA_SPACE_PUT && req.wdata == 8'h00 &&
		flag_evt == '0
		|=> ((store_reg[chk_idx_reg] ^ chk_old_reg) &
		iord_w1c_mask({2'b00, chk_idx_reg})) == 8'h00)
		else $error("flag changed by writing zero");

	single_bit_a: assert property (
		hit && bit_ok && flag_evt == '0 &&
		(req.op == OP_SET_IO_BIT_OP || req.op == OP_CLEAR_IO_BIT_OP)
		|=> ((store_reg[chk_idx_reg] ^ chk_old_reg) &
		~(8'h01 << chk_bit_reg)) == 8'h00)
		else $error("bit op disturbed another bit");

	port_direct_a: assert property (
		req.valid && req.op == OP_PORT_IN &&
		req.addr == ADDR_PORT_B_PIN
		|=> rsp.hit && rsp.rdata == $past(port_b_pins))
		else $error("port read of pin register wrong");

	data_offset_a: assert property (
		req.valid && req.op == OP_DATA_SPACE_LOAD &&
		req.addr == (DATA_OFS + ADDR_SCRATCH_0)
		|=> rsp.hit && rsp.rdata == chk_old_reg)
		else $error("data-space offset not applied");

	low_data_miss_a: assert property (
		req.valid && req.op == OP_DATA_SPACE_LOAD && req.addr < DATA_OFS
		|=> !rsp.hit && rsp.rdata == 8'h00)
		else $error("data-space address below offset hit");

	reserved_zero_a: assert property (
		hit && req.op == OP_PORT_IN && iord_rd_mask(io_addr) == 8'h00
		|=> rsp.rdata == 8'h00)
		else $error("reserved address read nonzero");

	no_wait_a: assert property (
		req.valid ##1 !req.valid |-> rsp.valid ##1 !rsp.valid)
		else $error("answer not exactly one cycle later");

	set_wins_a: assert property (
		hit && req.op == OP_PORT_OUT && io_addr == ADDR_WATCHDOG_CTRL &&
		req.wdata[7] && flag_evt.watchdog[7]
		|=> store_reg[ADDR_WATCHDOG_CTRL][7])
		else $error("flag set lost to a same-cycle clear");

	// the checks below pair with the ones above: together they
	// cover both what must change and what must stay put
	high_clear_blocked_a: assert property (
		req.valid && req.op == OP_CLEAR_IO_BIT_OP &&
		io_addr > BIT_TOP && flag_evt == '0
		|=> store_reg == $past(store_reg))
		else $error("bit clear reached an address above 0x1f");

	bit_set_lands_a: assert property (
		hit && io_addr <= BIT_TOP && req.op == OP_SET_IO_BIT_OP &&
		((8'h01 << req.bit_sel) & iord_wr_mask(io_addr) &
		~iord_w1c_mask(io_addr)) != 8'h00
		|=> store_reg[chk_idx_reg][chk_bit_reg])
		else $error("bit set did not set the addressed bit");

	bit_clear_lands_a: assert property (
		hit && io_addr <= BIT_TOP && req.op == OP_CLEAR_IO_BIT_OP &&
		((8'h01 << req.bit_sel) & iord_wr_mask(io_addr) &
		~iord_w1c_mask(io_addr)) != 8'h00
		|=> !store_reg[chk_idx_reg][chk_bit_reg])
		else $error("bit clear did not clear the addressed bit");

	skip_range_a: assert property (
		req.valid && io_addr > BIT_TOP &&
		(req.op == OP_SKIP_WHEN_IO_BIT_HIGH ||
		req.op == OP_SKIP_WHEN_IO_BIT_LOW)
		|=> !rsp.skip)
		else $error("skip test answered above 0x1f");

	miss_zero_a: assert property (
		req.valid && !hit
		|=> rsp.valid && !rsp.hit && !rsp.skip && rsp.rdata == 8'h00)
		else $error("refused access answered with data");

	miss_no_write_a: assert property (
		req.valid && !hit && flag_evt == '0
		|=> store_reg == $past(store_reg))
		else $error("refused access changed a register");

	rsp_idle_a: assert property (
		!req.valid |=> rsp == '0)
		else $error("answer without a request");

	bit_set_c: cover property (
		hit && bit_ok && req.op == OP_SET_IO_BIT_OP);
	flag_clear_c: cover property (
		hit && req.op == OP_PORT_OUT &&
		(req.wdata & iord_w1c_mask(io_addr)) != 8'h00);
	data_load_c: cover property (
		hit && req.op == OP_DATA_SPACE_LOAD ##1 rsp.valid);
	skip_taken_c: cover property (rsp.valid && rsp.skip);
	set_wins_c: cover property (
		hit && req.op == OP_PORT_OUT && io_addr == ADDR_WATCHDOG_CTRL &&
		req.wdata[7] && flag_evt.watchdog[7]);

endmodule
`default_nettype wire

/* hw/iord_pkg.sv */
`default_nettype none
package iord_pkg;
	// io window covered here: io addresses 0x00 to 0x29
	localparam int          IO_REGS   = 42;
	localparam logic [7:0]  IO_TOP    = 8'h3f;
	localparam logic [7:0]  BIT_TOP   = 8'h1f;
	localparam logic [7:0]  DATA_OFS  = 8'h20;
	localparam logic [7:0]  RESET_VAL = 8'h00;

	// register offsets (io addresses)
	localparam logic [7:0] ADDR_DIGITAL_INPUT_DIS = 8'h01;
	localparam logic [7:0] ADDR_SERIAL_BAUD_HIGH  = 8'h02;
	localparam logic [7:0] ADDR_SERIAL_FRAME_CFG  = 8'h03;
	localparam logic [7:0] ADDR_COMPARATOR_CTRL   = 8'h08;
	localparam logic [7:0] ADDR_SERIAL_BAUD_LOW   = 8'h09;
	localparam logic [7:0] ADDR_SERIAL_CONTROL_B  = 8'h0a;
	localparam logic [7:0] ADDR_SERIAL_STATUS_A   = 8'h0b;
	localparam logic [7:0] ADDR_SERIAL_DATA_BUF   = 8'h0c;
	localparam logic [7:0] ADDR_USI_CONTROL       = 8'h0d;
	localparam logic [7:0] ADDR_USI_STATUS        = 8'h0e;
	localparam logic [7:0] ADDR_USI_DATA          = 8'h0f;
	localparam logic [7:0] ADDR_PORT_D_PIN        = 8'h10;
	localparam logic [7:0] ADDR_PORT_D_DIR        = 8'h11;
	localparam logic [7:0] ADDR_PORT_D_OUT        = 8'h12;
	localparam logic [7:0] ADDR_SCRATCH_0         = 8'h13;
	localparam logic [7:0] ADDR_SCRATCH_1         = 8'h14;
	localparam logic [7:0] ADDR_SCRATCH_2         = 8'h15;
	localparam logic [7:0] ADDR_PORT_B_PIN        = 8'h16;
	localparam logic [7:0] ADDR_PORT_B_DIR        = 8'h17;
	localparam logic [7:0] ADDR_PORT_B_OUT        = 8'h18;
	localparam logic [7:0] ADDR_PORT_A_PIN        = 8'h19;
	localparam logic [7:0] ADDR_PORT_A_DIR        = 8'h1a;
	localparam logic [7:0] ADDR_PORT_A_OUT        = 8'h1b;
	localparam logic [7:0] ADDR_NVM_CONTROL       = 8'h1c;
	localparam logic [7:0] ADDR_NVM_DATA          = 8'h1d;
	localparam logic [7:0] ADDR_NVM_ADDRESS       = 8'h1e;
	localparam logic [7:0] ADDR_PIN_CHANGE_MASK   = 8'h20;
	localparam logic [7:0] ADDR_WATCHDOG_CTRL     = 8'h21;
	localparam logic [7:0] ADDR_T1_FORCE_COMPARE  = 8'h22;
	localparam logic [7:0] ADDR_GEN_TIMER_CTRL    = 8'h23;
	localparam logic [7:0] ADDR_T1_CAPTURE_LOW    = 8'h24;
	localparam logic [7:0] ADDR_T1_CAPTURE_HIGH   = 8'h25;
	localparam logic [7:0] ADDR_CLOCK_PRESCALE    = 8'h26;
	localparam logic [7:0] ADDR_T1_CMP_B_LOW      = 8'h28;
	localparam logic [7:0] ADDR_T1_CMP_B_HIGH     = 8'h29;

	typedef enum logic [2:0] {
		OP_PORT_IN               = 3'b000,
		OP_PORT_OUT              = 3'b001,
		OP_DATA_SPACE_LOAD       = 3'b010,
		OP_DATA_SPACE_PUT        = 3'b011,
		OP_SET_IO_BIT_OP         = 3'b100,
		OP_CLEAR_IO_BIT_OP       = 3'b101,
		OP_SKIP_WHEN_IO_BIT_HIGH = 3'b110,
		OP_SKIP_WHEN_IO_BIT_LOW  = 3'b111
	} iord_op_t;

	typedef struct packed {
		logic       valid;
		iord_op_t   op;
		logic [7:0] addr;
		logic [2:0] bit_sel;
		logic [7:0] wdata;
	} iord_req_t;

	typedef struct packed {
		logic       valid;
		logic       hit;
		logic       skip;
		logic [7:0] rdata;
	} iord_rsp_t;

	// per-register hardware flag set pulses
	typedef struct packed {
		logic [7:0] comparator;
		logic [7:0] serial_status;
		logic [7:0] usi_status;
		logic [7:0] watchdog;
	} iord_flag_evt_t;

	// implemented bits; reserved bits and addresses read zero
	function automatic logic [7:0] iord_rd_mask(input logic [7:0] a);
		case (a)
			ADDR_DIGITAL_INPUT_DIS: return 8'h03;
			ADDR_SERIAL_BAUD_HIGH:  return 8'h0f;
			ADDR_SERIAL_FRAME_CFG:  return 8'h7f;
			ADDR_PORT_A_PIN, ADDR_PORT_A_DIR, ADDR_PORT_A_OUT: return 8'h07;
			ADDR_PORT_D_PIN, ADDR_PORT_D_DIR, ADDR_PORT_D_OUT: return 8'h7f;
			ADDR_NVM_CONTROL:       return 8'h3f;
			ADDR_NVM_ADDRESS:       return 8'h7f;
			ADDR_CLOCK_PRESCALE:    return 8'h8f;
			ADDR_GEN_TIMER_CTRL:    return 8'h01;
			ADDR_T1_FORCE_COMPARE:  return 8'h00;
			8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h1f, 8'h27: return 8'h00;
			default:                return 8'hff;
		endcase
	endfunction

	// bits a core write may change; pins are input only
	function automatic logic [7:0] iord_wr_mask(input logic [7:0] a);
		case (a)
			ADDR_PORT_A_PIN, ADDR_PORT_B_PIN, ADDR_PORT_D_PIN: return 8'h00;
			ADDR_T1_FORCE_COMPARE:  return 8'hc0;
			default:                return iord_rd_mask(a);
		endcase
	endfunction

	// status flags cleared by writing one
	function automatic logic [7:0] iord_w1c_mask(input logic [7:0] a);
		case (a)
			ADDR_COMPARATOR_CTRL: return 8'h10;
			ADDR_SERIAL_STATUS_A: return 8'h40;
			ADDR_USI_STATUS:      return 8'he0;
			ADDR_WATCHDOG_CTRL:   return 8'h80;
			default:              return 8'h00;
		endcase
	endfunction
endpackage
`default_nettype wire

/* tb/iord_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module iord_core_model
	import iord_pkg::*;
(
	input  wire logic      core_clk,
	output var  iord_req_t req,
	input  wire iord_rsp_t rsp
);
	// idle request from time zero
	initial begin
		req = '0;
	end

	// one access: driven after an edge, held until taken, answer next cycle
	task automatic access(input iord_op_t op, input logic [7:0] addr,
		input logic [2:0] bsel, input logic [7:0] wdata,
		output iord_rsp_t r);
		logic [7:0] io;
		logic       wr;
		wr = (op == OP_PORT_OUT) || (op == OP_DATA_SPACE_PUT) ||
			(op == OP_SET_IO_BIT_OP) || (op == OP_CLEAR_IO_BIT_OP);
		io = (op == OP_DATA_SPACE_PUT) ? addr - DATA_OFS : addr;
		if (wr && (io inside {8'h00, [8'h04:8'h07], 8'h1f, 8'h27})) begin
			r = '0;
			return;
		end
		// callers pass zero in reserved bits
		@(posedge core_clk);
		req <= {1'b1, op, addr, bsel, wdata};
		@(posedge core_clk);
		req <= '0;
		// answer stands for the cycle after the taking edge
		#1 r = rsp;
	endtask
endmodule
`default_nettype wire

/* tb/tb_iord_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_iord_decoder
	import iord_pkg::*;
;
	logic                    core_clk;
	logic                    sys_rst;
	iord_req_t               req;
	iord_rsp_t               rsp;
	iord_rsp_t               r;
	iord_flag_evt_t          flag_evt;
	logic [7:0]              port_a_pins;
	logic [7:0]              port_b_pins;
	logic [7:0]              port_d_pins;
	logic [IO_REGS-1:0][7:0] reg_view;
	int                      err_total;
	int                      n_tests;

	iord_decoder i_iord_decoder (
		.core_clk   (core_clk),
		.sys_rst    (sys_rst),
		.req        (req),
		.flag_evt   (flag_evt),
		.port_a_pins(port_a_pins),
		.port_b_pins(port_b_pins),
		.port_d_pins(port_d_pins),
		.rsp        (rsp),
		.reg_view   (reg_view)
	);

	iord_core_model i_iord_core_model (
		.core_clk(core_clk),
		.req     (req),
		.rsp     (rsp)
	);

	// free-running core clock, 100 MHz
	always #5 core_clk = ~core_clk;

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic cmp1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic io(input iord_op_t op, input logic [7:0] a,
		input logic [2:0] b, input logic [7:0] w);
		i_iord_core_model.access(op, a, b, w, r);
	endtask

	// every mapped slot reads zero after reset, answered in one cycle
	task automatic test_reset();
		for (int a = 0; a < IO_REGS; a++) begin
			io(OP_PORT_IN, a[7:0], 3'h0, 8'h00);
			cmp1(r.valid, 1'b1);
			cmp1(r.hit, 1'b1);
			cmp8(r.rdata, 8'h00);
			cmp8(reg_view[a], 8'h00);
		end
	endtask

	// pin slots show live levels, masked to the implemented bits
	task automatic test_pins();
		@(posedge core_clk);
		port_a_pins <= 8'hff;
		port_b_pins <= 8'h5a;
		port_d_pins <= 8'hff;
		io(OP_PORT_IN, ADDR_PORT_A_PIN, 3'h0, 8'h00);
		cmp8(r.rdata, 8'h07);
		io(OP_PORT_IN, ADDR_PORT_D_PIN, 3'h0, 8'h00);
		cmp8(r.rdata, 8'h7f);
		io(OP_PORT_OUT, ADDR_PORT_B_PIN, 3'h0, 8'h00);
		io(OP_PORT_IN, ADDR_PORT_B_PIN, 3'h0, 8'h00);
		cmp8(r.rdata, 8'h5a);
	endtask

	// data space sees io registers shifted up by the fixed offset
	task automatic test_data_space();
		io(OP_DATA_SPACE_PUT, 8'h33, 3'h0, 8'h5a);
		cmp8(reg_view[8'h13], 8'h5a);
		io(OP_PORT_IN, 8'h13, 3'h0, 8'h00);
		cmp8(r.rdata, 8'h5a);
		io(OP_DATA_SPACE_LOAD, 8'h33, 3'h0, 8'h00);
		cmp8(r.rdata, 8'h5a);
		io(OP_DATA_SPACE_LOAD, 8'h13, 3'h0, 8'h00);
		cmp1(r.hit, 1'b0);
		cmp8(r.rdata, 8'h00);
		io(OP_DATA_SPACE_PUT, 8'h49, 3'h0, 8'hc3);
		io(OP_PORT_IN, 8'h29, 3'h0, 8'h00);
		cmp8(r.rdata, 8'hc3);
	endtask

	// top of the covered window and beyond the io range
	task automatic test_range();
		io(OP_PORT_OUT, 8'h29, 3'h0, 8'h3c);
		io(OP_PORT_IN, 8'h29, 3'h0, 8'h00);
		cmp8(r.rdata, 8'h3c);
		io(OP_PORT_OUT, ADDR_T1_FORCE_COMPARE, 3'h0, 8'hc0);
		io(OP_PORT_IN, ADDR_T1_FORCE_COMPARE, 3'h0, 8'h00);
		cmp8(r.rdata, 8'h00);
		io(OP_PORT_IN, 8'h3f, 3'h0, 8'h00);
		cmp1(r.hit, 1'b0);
		io(OP_PORT_IN, 8'h40, 3'h0, 8'h00);
		cmp1(r.valid, 1'b1);
		cmp1(r.hit, 1'b0);
		cmp8(r.rdata, 8'h00);
	endtask

	// single-bit set and clear, low range only
	task automatic test_bit_ops();
		io(OP_PORT_OUT, ADDR_PORT_D_OUT, 3'h0, 8'h41);
		io(OP_SET_IO_BIT_OP, ADDR_PORT_D_OUT, 3'h3, 8'h00);
		cmp8(reg_view[ADDR_PORT_D_OUT], 8'h49);
		io(OP_CLEAR_IO_BIT_OP, ADDR_PORT_D_OUT, 3'h0, 8'h00);
		cmp8(reg_view[ADDR_PORT_D_OUT], 8'h48);
		io(OP_PORT_OUT, ADDR_PIN_CHANGE_MASK, 3'h0, 8'h00);
		io(OP_SET_IO_BIT_OP, ADDR_PIN_CHANGE_MASK, 3'h2, 8'h00);
		cmp8(reg_view[ADDR_PIN_CHANGE_MASK], 8'h00);
	endtask

	// skip tests on scratch 0 holding 0x5a, and refused above 0x1f
	task automatic test_skip();
		io(OP_SKIP_WHEN_IO_BIT_HIGH, 8'h13, 3'h1, 8'h00);
		cmp1(r.skip, 1'b1);
		io(OP_SKIP_WHEN_IO_BIT_HIGH, 8'h13, 3'h0, 8'h00);
		cmp1(r.skip, 1'b0);
		io(OP_SKIP_WHEN_IO_BIT_LOW, 8'h13, 3'h0, 8'h00);
		cmp1(r.skip, 1'b1);
		io(OP_SKIP_WHEN_IO_BIT_LOW, 8'h13, 3'h1, 8'h00);
		cmp1(r.skip, 1'b0);
		io(OP_PORT_OUT, ADDR_PIN_CHANGE_MASK, 3'h0, 8'hff);
		io(OP_SKIP_WHEN_IO_BIT_HIGH, ADDR_PIN_CHANGE_MASK, 3'h0, 8'h00);
		cmp1(r.skip, 1'b0);
	endtask

	// flags set by hardware pulses, cleared only by writing one
	task automatic test_w1c();
		logic [7:0] ad[4] = '{8'h08, 8'h0b, 8'h0e, 8'h21};
		logic [7:0] mk[4] = '{8'h10, 8'h40, 8'he0, 8'h80};
		@(posedge core_clk);
		flag_evt <= {8'h10, 8'h40, 8'he0, 8'h80};
		@(posedge core_clk);
		flag_evt <= '0;
		for (int i = 0; i < 4; i++) begin
			io(OP_DATA_SPACE_PUT, ad[i] + DATA_OFS, 3'h0, 8'h00);
			cmp8(reg_view[ad[i]], mk[i]);
		end
		// bit ops leave the pending serial flag alone
		io(OP_SET_IO_BIT_OP, 8'h0b, 3'h1, 8'h00);
		cmp8(reg_view[8'h0b], 8'h42);
		io(OP_CLEAR_IO_BIT_OP, 8'h0b, 3'h6, 8'h00);
		cmp8(reg_view[8'h0b], 8'h42);
		for (int i = 0; i < 4; i++) begin
			io(OP_PORT_OUT, ad[i], 3'h0, mk[i] | ((i == 1) ? 8'h02 : 8'h00));
			cmp8(reg_view[ad[i]], (i == 1) ? 8'h02 : 8'h00);
		end
	endtask

	// hardware set and core clear of one flag in the same cycle
	task automatic test_set_wins();
		fork
			io(OP_PORT_OUT, ADDR_WATCHDOG_CTRL, 3'h0, 8'h80);
			begin
				@(posedge core_clk);
				flag_evt <= {8'h00, 8'h00, 8'h00, 8'h80};
				@(posedge core_clk);
				flag_evt <= '0;
			end
		join
		cmp8(reg_view[ADDR_WATCHDOG_CTRL], 8'h80);
		io(OP_PORT_OUT, ADDR_WATCHDOG_CTRL, 3'h0, 8'h80);
		cmp8(reg_view[ADDR_WATCHDOG_CTRL], 8'h00);
	endtask

	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		flag_evt = '0;
		port_a_pins = 8'h00;
		port_b_pins = 8'h00;
		port_d_pins = 8'h00;
		err_total = 0;
		n_tests = 0;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		test_reset();
		test_pins();
		test_data_space();
		test_range();
		test_bit_ops();
		test_skip();
		test_w1c();
		test_set_wins();
		finish_test();
	end

	// hang guard, far beyond the under two hundred cycles the tests need
	initial begin
		#100000;
		err_total++;
		finish_test();
	end
endmodule
`default_nettype wire
